// >>> soft_reset_param_pkg.sv
// constants for the soft reset and parameter table command block
`default_nettype none
package soft_reset_param_pkg;
  // opcodes
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET        = 8'h99;
  localparam logic [7:0] OP_PARAM_READ   = 8'h5a;
  // frame field lengths in serial clocks
  localparam int unsigned OPCODE_BITS    = 8;
  localparam int unsigned QUAD_OP_CLOCKS = 2;
  localparam int unsigned ADDR_BITS      = 24;
  localparam int unsigned DUMMY_CLOCKS   = 8;
  localparam int unsigned CNT_W          = 5;
  // recovery timing
  localparam int unsigned CLOCK_MHZ       = 200;
  localparam int unsigned RECOVERY_NS     = 30000;
  localparam int unsigned RECOVERY_CYCLES = (RECOVERY_NS * CLOCK_MHZ + 999) / 1000;
  localparam int unsigned RECOVERY_W      = 24;
  // table contents
  localparam logic [31:0] SIGNATURE       = 32'h50444653;
  localparam logic [7:0]  MINOR_REV       = 8'h00;
  localparam logic [7:0]  MAJOR_REV       = 8'h01;
  localparam logic [7:0]  HEADER_COUNT    = 8'h01;
  localparam logic [7:0]  UNUSED_BYTE     = 8'hff;
  localparam logic [7:0]  STD_TABLE_ID    = 8'h00;
  localparam logic [7:0]  STD_TABLE_LEN   = 8'h09;
  localparam logic [23:0] STD_TABLE_PTR   = 24'h000030;
  localparam logic [7:0]  VND_TABLE_LEN   = 8'h03;
  localparam logic [23:0] VND_TABLE_PTR   = 24'h000060;
  localparam logic [7:0]  ERASE_CAPS      = 8'he5;
  localparam logic [7:0]  ERASE_4K_OP     = 8'h20;
  localparam logic [7:0]  READ_CAPS       = 8'hf1;
  localparam logic [7:0]  QUAD_IO_TIMING  = 8'h44;
  localparam logic [7:0]  QUAD_IO_OP      = 8'heb;
  localparam logic [31:0] DENSITY_DEFAULT = 32'h003fffff;
  // arbitrary neutral identity value
  localparam logic [7:0]  VENDOR_ID_DEFAULT = 8'h5e;
  // state of the frame decoder
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_HOLD,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_SINK
  } frame_state_e;
endpackage
`default_nettype wire

// >>> soft_reset_param.sv
// serial command block for the two-step soft reset and the parameter table read
// Behaviour
// - accepted reset aborts internal operations and returns device to power-on state.
// - accepted reset clears all volatile bits, latches, suspend and mode settings.
// - both reset opcodes are accepted in single and quad transfer modes.
// - after an accepted reset every command is ignored until recovery ends.
// - opcode 5Ah reads the parameter table, single-bit mode only.
// - bytes 00h-03h give signature LSB first; 04h minor 00h, 05h major 01h.
// - byte 06h returns header count 01h, meaning two headers.
// - first header: ID 00h, rev 1.0, 9 dwords, pointer 000030h.
// - vendor header: its ID, rev 1.0, 3 dwords, pointer 000060h.
// - bytes 07h, 0Fh, 17h and 33h always read FFh, read only.
// - byte 30h reads E5h, byte 31h reads 4KB erase opcode 20h.
// - bits 3 and 4 of byte 30h read zero, nonvolatile status.
// - byte 32h reads F1h: 3-byte address, no DTR, four fast reads.
// - byte 38h reports 4 wait states and 2 mode clocks; 39h gives EBh.
`default_nettype none
module soft_reset_param
  import soft_reset_param_pkg::*;
#(
  parameter int unsigned RECOVERY  = RECOVERY_CYCLES,
  parameter logic [7:0]  VENDOR_ID = VENDOR_ID_DEFAULT,
  parameter logic [31:0] DENSITY   = DENSITY_DEFAULT
)
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // serial pins
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic [3:0] io_in,
  output logic            so,
  output logic            so_oe,
  // mode from the device configuration
  input  wire logic       quad_mode,
  // reset effects toward the rest of the device
  output logic            soft_reset_pulse,
  output logic            reset_armed,
  output logic            commands_blocked
);
  import soft_reset_param_pkg::*;
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [2:0] sck_s_q;
  logic [2:0] cs_s_q;
  logic [3:0] io_s1_q;
  logic [3:0] io_s2_q;
  logic       sck_lvl_q;
  logic       cs_lvl_q;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sck_s_q <= 3'h0;
      cs_s_q  <= 3'h7;
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
    end
    else
    begin
      sck_s_q <= {sck_s_q[1:0], sck};
      cs_s_q  <= {cs_s_q[1:0], cs_n};
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
    end
  end
  // a change counts once second and third stages agree
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sck_lvl_q <= 1'b0;
      cs_lvl_q  <= 1'b1;
    end
    else
    begin
      if (sck_s_q[1] == sck_s_q[2])
        sck_lvl_q <= sck_s_q[2];
      if (cs_s_q[1] == cs_s_q[2])
        cs_lvl_q <= cs_s_q[2];
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  assign sck_rise = (sck_s_q[1] == sck_s_q[2]) && sck_s_q[2] && !sck_lvl_q;
  assign sck_fall = (sck_s_q[1] == sck_s_q[2]) && !sck_s_q[2] && sck_lvl_q;
  assign cs_fall  = (cs_s_q[1] == cs_s_q[2]) && !cs_s_q[2] && cs_lvl_q;
  assign cs_rise  = (cs_s_q[1] == cs_s_q[2]) && cs_s_q[2] && !cs_lvl_q;
  // ************************************************************
  // parameter table
  // ************************************************************
  function automatic logic [7:0] table_byte(input logic [23:0] a);
    logic [7:0] b;
    b = UNUSED_BYTE;
    if (a[23:8] == 16'h0000)
    begin
      case (a[7:0])
        8'h00: b = SIGNATURE[7:0];
        8'h01: b = SIGNATURE[15:8];
        8'h02: b = SIGNATURE[23:16];
        8'h03: b = SIGNATURE[31:24];
        8'h04: b = MINOR_REV;
        8'h05: b = MAJOR_REV;
        8'h06: b = HEADER_COUNT;
        8'h08: b = STD_TABLE_ID;
        8'h09: b = MINOR_REV;
        8'h0a: b = MAJOR_REV;
        8'h0b: b = STD_TABLE_LEN;
        8'h0c: b = STD_TABLE_PTR[7:0];
        8'h0d: b = STD_TABLE_PTR[15:8];
        8'h0e: b = STD_TABLE_PTR[23:16];
        8'h10: b = VENDOR_ID;
        8'h11: b = MINOR_REV;
        8'h12: b = MAJOR_REV;
        8'h13: b = VND_TABLE_LEN;
        8'h14: b = VND_TABLE_PTR[7:0];
        8'h15: b = VND_TABLE_PTR[15:8];
        8'h16: b = VND_TABLE_PTR[23:16];
        8'h30: b = ERASE_CAPS;
        8'h31: b = ERASE_4K_OP;
        8'h32: b = READ_CAPS;
        8'h34: b = DENSITY[7:0];
        8'h35: b = DENSITY[15:8];
        8'h36: b = DENSITY[23:16];
        8'h37: b = DENSITY[31:24];
        8'h38: b = QUAD_IO_TIMING;
        8'h39: b = QUAD_IO_OP;
        default: b = UNUSED_BYTE;
      endcase
    end
    return b;
  endfunction
  // ************************************************************
  // frame decoder
  // ************************************************************
  frame_state_e         state_q;
  logic [CNT_W-1:0]     cnt_q;
  logic [7:0]           op_q;
  logic [23:0]          addr_q;
  logic [2:0]           bit_q;
  logic [RECOVERY_W-1:0] rec_q;
  logic                 armed_q;
  logic                 pulse_q;
  logic                 so_q;
  logic                 so_oe_q;
  logic [7:0]           op_d;
  logic                 op_last;
  // single mode takes one bit a clock, quad mode a nibble
  always_comb
  begin
    op_d    = quad_mode ? {op_q[3:0], io_s2_q} : {op_q[6:0], io_s2_q[0]};
    op_last = quad_mode ? (cnt_q == CNT_W'(QUAD_OP_CLOCKS - 1))
                        : (cnt_q == CNT_W'(OPCODE_BITS - 1));
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      op_q    <= 8'h00;
      addr_q  <= 24'h000000;
    end
    else if (cs_rise)
      state_q <= ST_IDLE;
    else if (cs_fall)
    begin
      state_q <= (rec_q != '0) ? ST_SINK : ST_OPCODE;
      cnt_q   <= '0;
    end
    else if (sck_rise)
    begin
      case (state_q)
        ST_OPCODE:
        begin
          op_q  <= op_d;
          cnt_q <= cnt_q + CNT_W'(1);
          if (op_last)
          begin
            cnt_q <= '0;
            if (op_d == OP_RESET_ENABLE || op_d == OP_RESET)
              state_q <= ST_HOLD;
            else if (op_d == OP_PARAM_READ && !quad_mode)
              state_q <= ST_ADDR;
            else
              state_q <= ST_SINK;
          end
        end
        // extra clocks spoil a reset frame
        ST_HOLD:
          state_q <= ST_SINK;
        ST_ADDR:
        begin
          addr_q <= {addr_q[22:0], io_s2_q[0]};
          cnt_q  <= cnt_q + CNT_W'(1);
          if (cnt_q == CNT_W'(ADDR_BITS - 1))
          begin
            cnt_q   <= '0;
            state_q <= ST_DUMMY;
          end
        end
        ST_DUMMY:
        begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (cnt_q == CNT_W'(DUMMY_CLOCKS - 1))
            state_q <= ST_DATA;
        end
        ST_IDLE, ST_DATA, ST_SINK:
          state_q <= state_q;
        default:
          state_q <= ST_SINK;
      endcase
    end
    else if (sck_fall && state_q == ST_DATA && bit_q == 3'h0 && so_oe_q)
      addr_q <= addr_q + 24'h000001;
  end
  // ************************************************************
  // serial output
  // ************************************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
      bit_q   <= 3'h7;
    end
    else if (state_q != ST_DATA || cs_rise)
    begin
      so_oe_q <= 1'b0;
      bit_q   <= 3'h7;
    end
    else if (sck_fall)
    begin
      so_oe_q <= 1'b1;
      so_q    <= |(table_byte(addr_q) & (8'h01 << bit_q));
      bit_q   <= bit_q - 3'h1;
    end
  end
  // ************************************************************
  // reset sequence
  // ************************************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      armed_q <= 1'b0;
      pulse_q <= 1'b0;
      rec_q   <= '0;
    end
    else
    begin
      pulse_q <= 1'b0;
      if (rec_q != '0)
        rec_q <= rec_q - RECOVERY_W'(1);
      if (cs_rise)
      begin
        // only the frame right after enable
        armed_q <= (state_q == ST_HOLD) && (op_q == OP_RESET_ENABLE);
        if (state_q == ST_HOLD && op_q == OP_RESET && armed_q)
        begin
          pulse_q <= 1'b1;
          rec_q   <= RECOVERY_W'(RECOVERY);
        end
      end
    end
  end
  assign so               = so_q;
  assign so_oe            = so_oe_q;
  assign soft_reset_pulse = pulse_q;
  assign reset_armed      = armed_q;
  assign commands_blocked = (rec_q != '0);
endmodule
`default_nettype wire

// >>> soft_reset_param_chk.sv
// port assertions for the soft reset and table block
`default_nettype none
module soft_reset_param_chk
  import soft_reset_param_pkg::*;
#(
  parameter int unsigned RECOVERY = RECOVERY_CYCLES
)
(
  // ports watched
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       sck,
  input wire logic       cs_n,
  input wire logic       so,
  input wire logic       so_oe,
  input wire logic       quad_mode,
  input wire logic       soft_reset_pulse,
  input wire logic       commands_blocked
);
  timeunit 1ns;
  timeprecision 1ps;
  //****************
  // checks
  //****************
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [23:0] blk_q;
  logic [3:0]  hi_q;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      blk_q <= 24'h0;
      hi_q  <= 4'h0;
    end
    else
    begin
      blk_q <= commands_blocked ? blk_q + 24'h1 : 24'h0;
      hi_q  <= !cs_n ? 4'h0 : (hi_q == 4'hf) ? hi_q : hi_q + 4'h1;
    end
  end
  a_pulse_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("reset pulse too long");
  a_pulse_cs_high: assert property (soft_reset_pulse |-> cs_n && !sck)
    else $error("reset pulse inside a frame");
  a_pulse_blocks: assert property (soft_reset_pulse |=> commands_blocked)
    else $error("no recovery after reset");
  a_recovery_len: assert property ($fell(commands_blocked) |-> blk_q == 24'(RECOVERY))
    else $error("recovery length wrong");
  a_block_bound: assert property (blk_q <= 24'(RECOVERY))
    else $error("recovery too long");
  a_oe_idle: assert property (hi_q >= 4'ha |-> !so_oe)
    else $error("output driven while deselected");
  a_oe_rise: assert property ($rose(so_oe) |-> !sck && !cs_n && !quad_mode)
    else $error("output enabled wrongly");
  a_so_hold: assert property (sck && so_oe |-> $stable(so))
    else $error("data moved while clock high");
  c_pulse: cover property (soft_reset_pulse);
  c_oe: cover property ($rose(so_oe));
  c_done: cover property ($fell(commands_blocked));
endmodule
bind soft_reset_param soft_reset_param_chk #(.RECOVERY(RECOVERY)) u_chk (
  .clock(clock), .rst(rst), .sck(sck), .cs_n(cs_n), .so(so), .so_oe(so_oe),
  .quad_mode(quad_mode), .soft_reset_pulse(soft_reset_pulse),
  .commands_blocked(commands_blocked));
`default_nettype wire

// >>> spi_host.sv
// serial host model driving the flash command pins
`default_nettype none
module spi_host (
  // clock and pins
  input  wire logic       clock,
  input  wire logic       so,
  output logic            sck,
  output logic            cs_n,
  output logic [3:0]      io_in
);
  timeunit 1ns;
  timeprecision 1ps;
  //****************
  // frame tasks
  //****************
  initial
  begin
    sck   = 1'b0;
    cs_n  = 1'b1;
    io_in = 4'h0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic bit_io(input logic [3:0] d, output logic s);
    io_in <= d;
    wt(6);
    s = so;
    sck <= 1'b1;
    wt(6);
    sck <= 1'b0;
  endtask
  task automatic open_f();
    cs_n <= 1'b0;
    wt(6);
  endtask
  task automatic close_f();
    wt(2);
    cs_n  <= 1'b1;
    io_in <= ~io_in;
    wt(12);
  endtask
  task automatic put_byte(input logic [7:0] b, input logic quad);
    logic s;
    if (quad)
    begin
      bit_io(b[7:4], s);
      bit_io(b[3:0], s);
    end
    else
      for (int i = 7; i >= 0; i--)
        bit_io({~io_in[3:1], b[i]}, s);
  endtask
  task automatic get_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      bit_io({~io_in[3:1], 1'b0}, b[i]);
  endtask
  task automatic send(input logic [7:0] b, input logic quad);
    open_f();
    put_byte(b, quad);
    close_f();
  endtask
endmodule
`default_nettype wire

// >>> soft_reset_param_tb.sv
// testbench for the soft reset and table block
`default_nettype none
module soft_reset_param_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import soft_reset_param_pkg::*;
  //****************
  // bench
  //****************
  localparam int unsigned REC = 300;
  // arbitrary vendor value
  localparam logic [7:0]  VID = 8'h3c;
  localparam logic [191:0] HDR = {56'hff000060030100, VID,
                                  128'hff00003009010000ff01010050444653};
  localparam logic [79:0] PRM = 80'heb44003ffffffff120e5;
  logic       clock, rst, quad_mode, so, so_oe, sck, cs_n, s;
  logic       soft_reset_pulse, reset_armed, commands_blocked;
  logic [3:0] io_in;
  int         mismatches = 0;
  int         compares = 0;
  int         pulses = 0;
  soft_reset_param #(.RECOVERY(REC), .VENDOR_ID(VID)) uut (
    .clock(clock), .rst(rst), .sck(sck), .cs_n(cs_n), .io_in(io_in), .so(so),
    .so_oe(so_oe), .quad_mode(quad_mode), .soft_reset_pulse(soft_reset_pulse),
    .reset_armed(reset_armed), .commands_blocked(commands_blocked));
  spi_host h (.clock(clock), .so(so), .sck(sck), .cs_n(cs_n), .io_in(io_in));
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock)
    if (soft_reset_pulse === 1'b1)
      pulses <= pulses + 1;
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [7:0] exp_b(input logic [23:0] a);
    if (a < 24'h18)
      return HDR[a[4:0]*8 +: 8];
    if (a >= 24'h30 && a < 24'h3a)
      return PRM[(a[4:0] - 5'h10)*8 +: 8];
    return 8'hff;
  endfunction
  task automatic t_reset(input logic q);
    int p;
    p = pulses;
    chk1(commands_blocked, 1'b0);
    quad_mode <= q;
    h.send(OP_RESET_ENABLE, q);
    chk1(reset_armed, 1'b1);
    h.send(OP_RESET, q);
    chk8(8'(pulses - p), 8'h1);
    chk1(commands_blocked, 1'b1);
    h.send(OP_RESET_ENABLE, q);
    chk1(reset_armed, 1'b0);
    for (int i = 0; i < 400 && commands_blocked !== 1'b0; i++)
      h.wt(1);
    chk1(commands_blocked, 1'b0);
    if (commands_blocked !== 1'b0)
      report_and_stop();
    quad_mode <= 1'b0;
  endtask
  task automatic t_refuse();
    int p;
    p = pulses;
    h.send(OP_RESET, 1'b0);
    h.send(OP_RESET_ENABLE, 1'b0);
    h.send(8'h00, 1'b0);
    chk1(reset_armed, 1'b0);
    h.send(OP_RESET, 1'b0);
    h.open_f();
    h.put_byte(OP_RESET_ENABLE, 1'b0);
    h.bit_io(4'h0, s);
    h.close_f();
    chk1(reset_armed, 1'b0);
    h.send(OP_RESET, 1'b0);
    chk8(8'(pulses - p), 8'h0);
  endtask
  task automatic t_quad_read();
    quad_mode <= 1'b1;
    h.open_f();
    repeat (4) h.put_byte(OP_PARAM_READ, 1'b1);
    repeat (40) h.bit_io(4'h0, s);
    chk1(so_oe, 1'b0);
    h.close_f();
    quad_mode <= 1'b0;
  endtask
  task automatic rd(input logic [23:0] a, input int n);
    logic [7:0] b;
    h.open_f();
    h.put_byte(OP_PARAM_READ, 1'b0);
    for (int i = 2; i >= 0; i--)
      h.put_byte(a[8*i +: 8], 1'b0);
    repeat (DUMMY_CLOCKS) h.bit_io(4'h0, s);
    for (int i = 0; i < n; i++)
    begin
      h.get_byte(b);
      chk8(b, exp_b(a + 24'(i)));
    end
    chk1(so_oe, 1'b1);
    h.close_f();
  endtask
  initial
  begin
    rst       = 1'b1;
    quad_mode = 1'b0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    h.wt(6);
    t_reset(1'b0);
    t_reset(1'b1);
    t_refuse();
    t_quad_read();
    rd(24'h000000, 26);
    rd(24'h00002e, 14);
    report_and_stop();
  end
endmodule
`default_nettype wire
